// ### dcd_decoder.sv
// Summary of operation
// - record is zero, tag, length, then values
// - tag 06 sets minutes interval, LSB first
// - tag 07 selects the uplink telegram format
// - formats 24..29 and 2C are selectable
// - format 2D is never accepted
// - format 2C sends ids 2C then 2D
// - tag 0F power saving, 00 disables
// - power saving 01 ten years, 02 six
// - tag 13 adds signed minutes to time
// - top bit of second byte means subtract
// - tag 17 replaces the offset from UTC
// - negative offset uses the same sign bit
// - tag 22 reboots only on key 9E 75
// - tag 1D sets the pulse input mask
// - mask bits 0..2 select inputs 1..3
// - engaged lock blocks setting changes; opens at reset; bus writes to the time register still go through
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_decoder (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // uplink side
    input  wire logic        tlg_req,
    output logic [7:0]       tlg_id,
    output logic             tlg_valid,
    // settings seen by the rest of the device
    output logic             config_locked,
    output logic [15:0]      tx_interval_min,
    output logic [7:0]       telegram_format,
    output logic [1:0]       power_saving_mode,
    output logic [31:0]      time_min,
    output logic [15:0]      utc_offset_min,
    output logic [2:0]       pulse_mask,
    output logic             reboot_req
);
    import dcd_pkg::*;

    dcd_state_t st;
    dcd_state_t next_st;

    // sign-and-magnitude minutes, low byte first, to two's complement
    function automatic logic signed [15:0] dcd_sm_minutes(input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] mag;
        mag = {1'b0, hi[`DCD_SM_SIGN_BIT-1:0], lo};
        if (hi[`DCD_SM_SIGN_BIT]) begin
            dcd_sm_minutes = -$signed(mag);
        end else begin
            dcd_sm_minutes = $signed(mag);
        end
    endfunction : dcd_sm_minutes

    // selectable telegram formats; the second pulse telegram id is not among them
    function automatic logic dcd_fmt_ok(input logic [7:0] code);
        unique case (code)
            `DCD_FMT_STD,
            `DCD_FMT_COMPACT,
            `DCD_FMT_TEXT,
            `DCD_FMT_DAILY,
            `DCD_FMT_EXT,
            `DCD_FMT_COMB,
            `DCD_FMT_PULSE: dcd_fmt_ok = 1'b1;
            default:        dcd_fmt_ok = 1'b0;
        endcase
    endfunction : dcd_fmt_ok

    // register read mux, sampled in the address phase
    function automatic logic [31:0] dcd_read(input dcd_state_t s, input logic [7:0] addr);
        unique case (addr)
            `DCD_OFF_CTRL:        dcd_read = {29'h0000_0000, s.ps};
            `DCD_OFF_STATUS:      dcd_read = {21'h00_0000, s.applied, s.result};
            `DCD_OFF_LOCK:        dcd_read = {31'h0000_0000, s.lock};
            `DCD_OFF_TX_INTERVAL: dcd_read = {16'h0000, s.tx_interval};
            `DCD_OFF_FORMAT:      dcd_read = {24'h00_0000, s.fmt};
            `DCD_OFF_POWER_SAVE:  dcd_read = {30'h0000_0000, s.psm};
            `DCD_OFF_TIME_MIN:    dcd_read = s.time_min;
            `DCD_OFF_UTC_OFFSET:  dcd_read = {{16{s.utc_offset[15]}}, s.utc_offset};
            `DCD_OFF_PULSE_MASK:  dcd_read = {24'h00_0000, s.pmask};
            default:              dcd_read = 32'h0000_0000;
        endcase
    endfunction : dcd_read

    logic        addr_phase;
    logic        byte_v;
    logic [7:0]  byte_d;
    logic        commit;
    logic [7:0]  c_v0;
    logic [7:0]  c_v1;
    logic [7:0]  cnt_inc;
    dcd_result_t res;

    assign addr_phase = hsel & htrans[1] & hready;

    always_comb begin
        next_st          = st;
        next_st.reboot   = 1'b0;
        next_st.tlg_kick = 1'b0;
        next_st.wr_pend  = 1'b0;
        next_st.hreadyout = 1'b1;
        byte_v           = 1'b0;
        byte_d           = hwdata[7:0];
        commit           = 1'b0;
        c_v0             = st.val0;
        c_v1             = st.val1;
        cnt_inc          = st.cnt + 8'h01;
        res              = DCD_RES_APPLIED;

        // address phase: capture writes, fetch reads
        if (addr_phase) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr[7:0];
            if (!hwrite) begin
                next_st.hrdata = dcd_read(st, haddr[7:0]);
            end
        end

        // data phase of a write
        if (st.wr_pend) begin
            unique case (st.wr_addr)
                `DCD_OFF_CTRL: begin
                    if (hwdata[`DCD_CTRL_RESTART_BIT]) begin
                        next_st.ps = DCD_PS_LEAD;
                    end
                end
                `DCD_OFF_BYTE:     byte_v = 1'b1;
                `DCD_OFF_TIME_MIN: next_st.time_min = hwdata;
                `DCD_OFF_TLG:      next_st.tlg_kick = hwdata[`DCD_TLG_KICK_BIT];
                default: ;
            endcase
        end

        // byte-serial record parser
        if (byte_v) begin
            unique case (st.ps)
                DCD_PS_LEAD: begin
                    if (byte_d == `DCD_LEAD_BYTE) begin
                        next_st.ps = DCD_PS_TAG;
                    end else begin
                        // framing lost: drop the rest until software restarts the parser
                        next_st.ps     = DCD_PS_DISCARD;
                        next_st.result = DCD_RES_BAD_LEAD;
                    end
                end
                DCD_PS_TAG: begin
                    next_st.tag = byte_d;
                    next_st.ps  = DCD_PS_LEN;
                end
                DCD_PS_LEN: begin
                    next_st.len = byte_d;
                    next_st.cnt = 8'h00;
                    if (byte_d == 8'h00) begin
                        commit     = 1'b1;
                        next_st.ps = DCD_PS_LEAD;
                    end else begin
                        next_st.ps = DCD_PS_VAL;
                    end
                end
                DCD_PS_VAL: begin
                    // only two value bytes are kept; longer records fail the length check
                    if (st.cnt == 8'h00) begin
                        c_v0         = byte_d;
                        next_st.val0 = byte_d;
                    end
                    if (st.cnt == 8'h01) begin
                        c_v1         = byte_d;
                        next_st.val1 = byte_d;
                    end
                    next_st.cnt = cnt_inc;
                    if (cnt_inc == st.len) begin
                        commit     = 1'b1;
                        next_st.ps = DCD_PS_LEAD;
                    end
                end
                DCD_PS_DISCARD: ;
                default: next_st.ps = DCD_PS_DISCARD;
            endcase
        end

        // apply a complete record; the tag comes from the register, the length may be fresh
        if (commit) begin
            unique case (st.tag)
                `DCD_TAG_LOCK: begin
                    // the lock command itself is always honoured, otherwise a lock could never open
                    if (next_st.len != `DCD_LEN_LOCK) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (c_v0 == `DCD_LOCK_ENGAGE) begin
                        next_st.lock = 1'b1;
                    end else if (c_v0 == `DCD_LOCK_OPEN) begin
                        next_st.lock = 1'b0;
                    end else begin
                        res = DCD_RES_BAD_VAL;
                    end
                end
                `DCD_TAG_TXI: begin
                    if (next_st.len != `DCD_LEN_TXI) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else if ({c_v1, c_v0} == 16'h0000) begin
                        res = DCD_RES_BAD_VAL;
                    end else begin
                        next_st.tx_interval = {c_v1, c_v0};
                    end
                end
                `DCD_TAG_FMT: begin
                    if (next_st.len != `DCD_LEN_FMT) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else if (!dcd_fmt_ok(c_v0)) begin
                        res = DCD_RES_BAD_VAL;
                    end else begin
                        next_st.fmt = c_v0;
                    end
                end
                `DCD_TAG_PSM: begin
                    if (next_st.len != `DCD_LEN_PSM) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else if (c_v0 > {6'h00, `DCD_PSM_6Y}) begin
                        res = DCD_RES_BAD_VAL;
                    end else begin
                        next_st.psm = c_v0[1:0];
                    end
                end
                `DCD_TAG_REL: begin
                    if (next_st.len != `DCD_LEN_REL) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else begin
                        next_st.time_min = st.time_min + 32'(dcd_sm_minutes(c_v0, c_v1));
                    end
                end
                `DCD_TAG_UTC: begin
                    if (next_st.len != `DCD_LEN_UTC) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else begin
                        next_st.utc_offset = dcd_sm_minutes(c_v0, c_v1);
                    end
                end
                `DCD_TAG_PMASK: begin
                    if (next_st.len != `DCD_LEN_PMASK) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (st.lock) begin
                        res = DCD_RES_LOCKED;
                    end else begin
                        // reserved bits are expected zero and are dropped anyway
                        next_st.pmask = c_v0 & `DCD_PMASK_USED;
                    end
                end
                `DCD_TAG_REBOOT: begin
                    if (next_st.len != `DCD_LEN_REBOOT) begin
                        res = DCD_RES_BAD_LEN;
                    end else if (c_v0 == `DCD_REBOOT_KEY0 && c_v1 == `DCD_REBOOT_KEY1) begin
                        next_st.reboot = 1'b1;
                    end else begin
                        res = DCD_RES_BAD_VAL;
                    end
                end
                default: res = DCD_RES_BAD_TAG;
            endcase
            next_st.result = res;
            if (res == DCD_RES_APPLIED) begin
                next_st.applied = st.applied + 8'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st             <= '0;
            st.ps          <= DCD_PS_LEAD;
            st.lock        <= 1'b0;
            st.tx_interval <= `DCD_RST_TX_INTERVAL;
            st.fmt         <= `DCD_RST_FORMAT;
            st.psm         <= `DCD_RST_PSM;
            st.pmask       <= `DCD_RST_PMASK;
            st.result      <= DCD_RES_NONE;
            st.hreadyout   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    dcd_tlg_seq u_tlg_seq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .fmt       (st.fmt),
        .kick      (tlg_req | st.tlg_kick),
        .tlg_id    (tlg_id),
        .tlg_valid (tlg_valid)
    );

    // every answer is OKAY and zero wait
    assign hreadyout         = st.hreadyout;
    assign hresp             = 1'b0;
    assign hrdata            = st.hrdata;
    assign config_locked     = st.lock;
    assign tx_interval_min   = st.tx_interval;
    assign telegram_format   = st.fmt;
    assign power_saving_mode = st.psm;
    assign time_min          = st.time_min;
    assign utc_offset_min    = st.utc_offset;
    assign pulse_mask        = st.pmask[2:0];
    assign reboot_req        = st.reboot;

endmodule : dcd_decoder

// ### dcd_decoder_bench.sv
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_decoder_bench;
    import dcd_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, tlg_req, tlg_valid, config_locked, reboot_req;
    logic [31:0] haddr, hwdata, hrdata, time_min, q;
    logic [1:0]  htrans, power_saving_mode;
    logic [2:0]  hsize, pulse_mask;
    logic [7:0]  tlg_id, telegram_format;
    logic [15:0] tx_interval_min, utc_offset_min;
    logic [7:0]  fmts [7] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2C};
    int          fails, n_compared, n_boot, cyc;

    dcd_net_srv u_srv (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
    dcd_decoder u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .tlg_req(tlg_req), .tlg_id(tlg_id), .tlg_valid(tlg_valid),
        .config_locked(config_locked), .tx_interval_min(tx_interval_min),
        .telegram_format(telegram_format), .power_saving_mode(power_saving_mode), .time_min(time_min),
        .utc_offset_min(utc_offset_min), .pulse_mask(pulse_mask), .reboot_req(reboot_req));

    always #20 hclk = ~hclk;

    always @(posedge hclk) begin
        if (reboot_req === 1'b1) n_boot++;
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task st(input logic [2:0] e);
        u_srv.bus(1'b0, `DCD_OFF_STATUS, 32'h0, q);
        chk(q[2:0], e, "status");
    endtask : st

    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        tlg_req = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(config_locked, 0, "lock");
        chk(tx_interval_min, 16'h003C, "interval");
        chk(power_saving_mode, 2'h1, "psm");
        u_srv.bus(1'b0, 8'h40, 32'h0, q);
        chk(q, 0, "unmapped");
        $display("test reset finished");
        u_srv.cmd(8'h06, 8'h02, 16'h001E);
        chk(tx_interval_min, 16'h001E, "interval");
        st(3'h1);
        u_srv.cmd(8'h06, 8'h01, 16'h0005);
        st(3'h3);
        u_srv.cmd(8'h06, 8'h02, 16'h0000);
        st(3'h4);
        u_srv.cmd(8'h30, 8'h01, 16'h0001);
        st(3'h2);
        chk(tx_interval_min, 16'h001E, "interval kept");
        $display("test interval finished");
        foreach (fmts[i]) begin
            u_srv.cmd(8'h07, 8'h01, {8'h00, fmts[i]});
            chk(telegram_format, fmts[i], "format");
        end
        u_srv.cmd(8'h07, 8'h01, 16'h002D);
        chk(telegram_format, 8'h2C, "format 2D");
        tlg_req <= 1'b1;
        @(posedge hclk);
        tlg_req <= 1'b0;
        @(posedge hclk);
        chk({tlg_valid, tlg_id}, 9'h12C, "first id");
        @(posedge hclk);
        chk({tlg_valid, tlg_id}, 9'h12D, "second id");
        $display("test format finished");
        for (int v = 0; v < 4; v++) begin
            u_srv.cmd(8'h0F, 8'h01, v[15:0]);
            chk(power_saving_mode, (v < 3) ? v[1:0] : 2'h2, "psm");
        end
        u_srv.cmd(8'h13, 8'h02, 16'h000F);
        chk(time_min, 32'h0000000F, "time up");
        u_srv.cmd(8'h13, 8'h02, 16'h800F);
        u_srv.cmd(8'h13, 8'h02, 16'h800F);
        chk(time_min, 32'hFFFFFFF1, "time down");
        u_srv.cmd(8'h17, 8'h02, 16'h003C);
        chk(utc_offset_min, 16'h003C, "utc plus");
        u_srv.cmd(8'h17, 8'h02, 16'h803C);
        chk(utc_offset_min, 16'hFFC4, "utc minus");
        u_srv.cmd(8'h1D, 8'h01, 16'h0001);
        chk(pulse_mask, 3'h1, "mask");
        u_srv.cmd(8'h1D, 8'h01, 16'h0006);
        chk(pulse_mask, 3'h6, "mask");
        u_srv.cmd(8'h22, 8'h02, 16'h769E);
        repeat (3) @(posedge hclk);
        chk(n_boot, 0, "bad key");
        u_srv.cmd(8'h22, 8'h02, 16'h759E);
        repeat (3) @(posedge hclk);
        chk(n_boot, 1, "reboot");
        $display("test settings finished");
        u_srv.cmd(8'h05, 8'h01, 16'h0000);
        chk(config_locked, 1, "lock on");
        u_srv.cmd(8'h06, 8'h02, 16'h0010);
        st(3'h5);
        u_srv.cmd(8'h05, 8'h01, 16'h0001);
        chk(config_locked, 0, "lock off");
        u_srv.put(8'h55);
        u_srv.cmd(8'h06, 8'h02, 16'h0010);
        chk(tx_interval_min, 16'h001E, "bad lead");
        u_srv.bus(1'b1, `DCD_OFF_CTRL, 32'h1, q);
        u_srv.cmd(8'h06, 8'h02, 16'h0010);
        chk(tx_interval_min, 16'h0010, "restart");
        u_srv.bus(1'b0, `DCD_OFF_FORMAT, 32'h0, q);
        chk(q, 32'h0000002C, "format reg");
        u_srv.bus(1'b1, `DCD_OFF_TLG, 32'h1, q);
        @(posedge hclk);
        @(posedge hclk);
        chk({tlg_valid, tlg_id}, 9'h12C, "kick first id");
        @(posedge hclk);
        chk({tlg_valid, tlg_id}, 9'h12D, "kick second id");
        $display("test lock finished");
        give_verdict();
    end
endmodule : dcd_decoder_bench

// ### dcd_decoder_sva.sv
`timescale 1ns/1ps

module dcd_decoder_sva (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus answer
    input wire logic        hreadyout,
    input wire logic        hresp,
    // telegram ids
    input wire logic        tlg_req,
    input wire logic [7:0]  tlg_id,
    input wire logic        tlg_valid,
    // settings
    input wire logic        config_locked,
    input wire logic [15:0] tx_interval_min,
    input wire logic [7:0]  telegram_format,
    input wire logic [1:0]  power_saving_mode,
    input wire logic [2:0]  pulse_mask,
    input wire logic        reboot_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_first;
        tlg_valid && tlg_id == 8'h2C;
    endsequence
    sequence s_second;
        tlg_valid && tlg_id == 8'h2D;
    endsequence

    property p_okay;
        hresp == 1'b0 && hreadyout == 1'b1;
    endproperty
    property p_tlg;
        tlg_req && !tlg_valid |=> tlg_valid && tlg_id == $past(telegram_format);
    endproperty
    property p_pair;
        s_first |=> s_second;
    endproperty
    property p_fmt_set;
        telegram_format inside {8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2C};
    endproperty
    property p_fmt_no2d;
        telegram_format != 8'h2D;
    endproperty
    property p_psm;
        power_saving_mode != 2'h3;
    endproperty
    property p_boot;
        reboot_req |=> !reboot_req;
    endproperty
    // a held lock freezes interval, format, power saving and pulse mask; clock and UTC offset are not checked
    property p_lock;
        config_locked |=> $stable(tx_interval_min) && $stable(telegram_format)
            && $stable(power_saving_mode) && $stable(pulse_mask);
    endproperty
    property p_txi;
        tx_interval_min != 16'h0000;
    endproperty

    a_okay: assert property (p_okay) else $error("bus answer not okay/ready");
    a_tlg: assert property (p_tlg) else $error("telegram id not format");
    a_pair: assert property (p_pair) else $error("second telegram id missing");
    a_fmt_set: assert property (p_fmt_set) else $error("format outside list");
    a_fmt_no2d: assert property (p_fmt_no2d) else $error("format 2D selected");
    a_psm: assert property (p_psm) else $error("power saving code illegal");
    a_boot: assert property (p_boot) else $error("reboot pulse too long");
    a_lock: assert property (p_lock) else $error("setting changed while locked");
    a_txi: assert property (p_txi) else $error("interval zero");
endmodule : dcd_decoder_sva

bind dcd_decoder dcd_decoder_sva u_sva (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .tlg_req(tlg_req), .tlg_id(tlg_id), .tlg_valid(tlg_valid),
    .config_locked(config_locked), .tx_interval_min(tx_interval_min),
    .telegram_format(telegram_format), .power_saving_mode(power_saving_mode),
    .pulse_mask(pulse_mask), .reboot_req(reboot_req)
);

// ### dcd_net_srv.sv
`timescale 1ns/1ps
`include "dcd_regs.svh"

// network side: composes downlink records and carries them over the bus
module dcd_net_srv (
    // clock
    input  wire logic        hclk,
    // master side
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    // slave answer
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        // stale write data would hide a slave that samples too early
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task put(input logic [7:0] b);
        logic [31:0] q;
        bus(1'b1, `DCD_OFF_BYTE, {24'h0, b}, q);
    endtask : put

    // lead zero, tag, length, value low byte first; masks keep bits 3..7 clear
    task cmd(input logic [7:0] t, input logic [7:0] l, input logic [15:0] v);
        put(`DCD_LEAD_BYTE);
        put(t);
        put(l);
        for (int i = 0; i < l; i++) put(v[8*i +: 8]);
        // settings change at the last byte's edge; callers look one edge later
        @(posedge hclk);
    endtask : cmd
endmodule : dcd_net_srv

// ### dcd_pkg.sv
package dcd_pkg;

    typedef enum logic [2:0] {
        DCD_PS_LEAD    = 3'b000,
        DCD_PS_TAG     = 3'b001,
        DCD_PS_LEN     = 3'b010,
        DCD_PS_VAL     = 3'b011,
        DCD_PS_DISCARD = 3'b100
    } dcd_pstate_t;

    typedef enum logic [2:0] {
        DCD_RES_NONE     = 3'b000,
        DCD_RES_APPLIED  = 3'b001,
        DCD_RES_BAD_TAG  = 3'b010,
        DCD_RES_BAD_LEN  = 3'b011,
        DCD_RES_BAD_VAL  = 3'b100,
        DCD_RES_LOCKED   = 3'b101,
        DCD_RES_BAD_LEAD = 3'b110
    } dcd_result_t;

    typedef struct packed {
        dcd_pstate_t        ps;
        logic [7:0]         tag;
        logic [7:0]         len;
        logic [7:0]         cnt;
        logic [7:0]         val0;
        logic [7:0]         val1;
        logic               lock;
        logic [15:0]        tx_interval;
        logic [7:0]         fmt;
        logic [1:0]         psm;
        logic [31:0]        time_min;
        logic signed [15:0] utc_offset;
        logic [7:0]         pmask;
        dcd_result_t        result;
        logic [7:0]         applied;
        logic               reboot;
        logic               tlg_kick;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        hrdata;
        logic               hreadyout;
    } dcd_state_t;

    typedef struct packed {
        logic       sec_pend;
        logic [7:0] id;
        logic       valid;
    } dcd_seq_state_t;

endpackage : dcd_pkg

// ### dcd_regs.svh
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

// register byte offsets on the bus
`define DCD_OFF_CTRL        8'h00
`define DCD_OFF_BYTE        8'h04
`define DCD_OFF_STATUS      8'h08
`define DCD_OFF_LOCK        8'h0C
`define DCD_OFF_TX_INTERVAL 8'h10
`define DCD_OFF_FORMAT      8'h14
`define DCD_OFF_POWER_SAVE  8'h18
`define DCD_OFF_TIME_MIN    8'h1C
`define DCD_OFF_UTC_OFFSET  8'h20
`define DCD_OFF_PULSE_MASK  8'h24
`define DCD_OFF_TLG         8'h28

// field positions
`define DCD_CTRL_RESTART_BIT 0
`define DCD_TLG_KICK_BIT     0

// record framing
`define DCD_LEAD_BYTE   8'h00

// tags and their value lengths
`define DCD_TAG_LOCK    8'h05
`define DCD_LEN_LOCK    8'h01
`define DCD_TAG_TXI     8'h06
`define DCD_LEN_TXI     8'h02
`define DCD_TAG_FMT     8'h07
`define DCD_LEN_FMT     8'h01
`define DCD_TAG_PSM     8'h0F
`define DCD_LEN_PSM     8'h01
`define DCD_TAG_REL     8'h13
`define DCD_LEN_REL     8'h02
`define DCD_TAG_UTC     8'h17
`define DCD_LEN_UTC     8'h02
`define DCD_TAG_PMASK   8'h1D
`define DCD_LEN_PMASK   8'h01
`define DCD_TAG_REBOOT  8'h22
`define DCD_LEN_REBOOT  8'h02

// value codes
`define DCD_LOCK_ENGAGE 8'h00
`define DCD_LOCK_OPEN   8'h01
`define DCD_FMT_STD     8'h24
`define DCD_FMT_COMPACT 8'h25
`define DCD_FMT_TEXT    8'h26
`define DCD_FMT_DAILY   8'h27
`define DCD_FMT_EXT     8'h28
`define DCD_FMT_COMB    8'h29
`define DCD_FMT_PULSE   8'h2C
`define DCD_FMT_PULSE2  8'h2D
`define DCD_PSM_OFF     2'h0
`define DCD_PSM_10Y     2'h1
`define DCD_PSM_6Y      2'h2
`define DCD_REBOOT_KEY0 8'h9E
`define DCD_REBOOT_KEY1 8'h75
`define DCD_SM_SIGN_BIT 7
`define DCD_PMASK_USED  8'h07

// reset values
`define DCD_RST_TX_INTERVAL 16'h003C
`define DCD_RST_FORMAT      8'h24
`define DCD_RST_PSM         2'h1
`define DCD_RST_PMASK       8'h00

`endif

// ### dcd_tlg_seq.sv
`timescale 1ns/1ps
`include "dcd_regs.svh"

// telegram format-id sequencer: one kick gives one id, or two for the pulse format
module dcd_tlg_seq (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // request
    input  wire logic [7:0] fmt,
    input  wire logic       kick,
    // answer
    output logic      [7:0] tlg_id,
    output logic            tlg_valid
);
    import dcd_pkg::*;

    dcd_seq_state_t st;
    dcd_seq_state_t next_st;

    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        if (st.sec_pend) begin
            // the second telegram goes out first; a kick in this cycle is dropped
            next_st.id       = `DCD_FMT_PULSE2;
            next_st.valid    = 1'b1;
            next_st.sec_pend = 1'b0;
        end else if (kick) begin
            next_st.id       = fmt;
            next_st.valid    = 1'b1;
            next_st.sec_pend = (fmt == `DCD_FMT_PULSE);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tlg_id    = st.id;
    assign tlg_valid = st.valid;

endmodule : dcd_tlg_seq
